//--- hdl/twm_params.svh
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

// register byte addresses
`define TWM_ADDR_CTL 12'h000
`define TWM_ADDR_DATA 12'h004
`define TWM_ADDR_STAT 12'h008
`define TWM_ADDR_RATE 12'h00C

// control register bit positions
`define TWM_CTL_FLAG 7
`define TWM_CTL_ACKEN 6
`define TWM_CTL_STA 5
`define TWM_CTL_STO 4
`define TWM_CTL_WCOL 3
`define TWM_CTL_EN 2
`define TWM_CTL_IE 0

// status register layout
`define TWM_STAT_PRESC_HI 1
`define TWM_STAT_CODE_LO 3

// status codes, prescaler bits taken as zero
`define TWM_ST_START 8'h08
`define TWM_ST_RESTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_TX_ACK 8'h28
`define TWM_ST_TX_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_RX_ACK 8'h50
`define TWM_ST_RX_NACK 8'h58
`define TWM_ST_IDLE 8'hF8

// bit engine: quarter-bit reload count, reset value
`define TWM_RATE_RESET 8'h7C
`define TWM_PHASE_SCL 2'h1
`define TWM_PHASE_LAST 2'h3
`define TWM_BIT_ACK 4'h8

`endif

//--- hdl/twm_pkg.sv
package twm_pkg;

  typedef enum logic [5:0] {
    TWM_IDLE = 6'b000001,
    TWM_WAITFREE = 6'b000010,
    TWM_START = 6'b000100,
    TWM_BYTE = 6'b001000,
    TWM_STOP = 6'b010000,
    TWM_HOLD = 6'b100000
  } twm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } twm_apb_req_t;

  typedef struct packed {
    logic flag;
    logic ackEn;
    logic staReq;
    logic stoReq;
    logic wcol;
    logic en;
    logic ie;
  } twm_ctl_t;

  typedef struct packed {
    twm_state_t state;
    logic [1:0] phase;
    logic [3:0] bitIdx;
    logic [7:0] qCnt;
    logic [7:0] qLimit;
    logic [7:0] shift;
    logic [7:0] dataReg;
    logic [7:0] code;
    logic [1:0] presc;
    twm_ctl_t ctl;
    logic owner;
    logic rxMode;
    logic addrPhase;
    logic ackBit;
    logic ackSeen;
    logic busy;
    logic sclPrev;
    logic sdaPrev;
    logic sclOe;
    logic sdaOe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } twm_regs_t;

endpackage

//--- hdl/twm_sync.sv
module twm_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [WIDTH-1:0] asyncIn, // pins from outside the domain
  output logic [WIDTH-1:0] syncOut // two-stage synchronised copy
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : gBit
      logic meta_q;
      logic stable_q;
      // idle bus lines sit high, so reset to the released level
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          meta_q <= 1'b1;
          stable_q <= 1'b1;
        end
        else
        begin
          meta_q <= asyncIn[i];
          stable_q <= meta_q;
        end
      end
      assign syncOut[i] = stable_q;
    end
  endgenerate

endmodule

//--- hdl/twm_master.sv
// The register offsets and the APB register port were decided locally.
`include "twm_params.svh"

// Contract
// - status codes compare with the two prescaler bits masked to zero
// - a requested start waits until the bus is free
// - start sent sets the done flag with status 0x08
// - writing one clears the done flag; every bus step waits for it
// - address direction bit selects master transmit or master receive mode
// - read address and acknowledge done set flag with 0x38, 0x40 or 0x48
// - each received byte is valid in the data register when flag rises
// - after a sent data byte status is 0x28 on ack, 0x30 on nack
// - in 0x28 or 0x30 a clear with no start or stop sends next byte
// - clear with start one, stop zero sends a repeated start, bus kept
// - clear with stop one sends stop, then stop request clears itself
// - clear with start and stop one sends stop then start, stop request clears
// - arbitration lost gives 0x38; clear without start releases the bus
// - after arbitration loss, clear with start waits for free bus, then starts
// - repeated start gives 0x10 and any slave or direction may follow
// - data write while flag low is dropped and sets the collision flag
// - acknowledge enable at flag clear picks ack or nack for next received byte
module twm_master (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire twm_pkg::twm_apb_req_t apbReq, // apb request group
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic sclIn, // clock line level
  output logic sclOut, // clock line drive value
  output logic sclOe, // clock line pulled low when high
  input wire logic sdaIn, // data line level
  output logic sdaOut, // data line drive value
  output logic sdaOe // data line pulled low when high
);

  twm_pkg::twm_regs_t st_q;
  twm_pkg::twm_regs_t st_d;
  logic [1:0] lineSync;
  logic sclS;
  logic sdaS;
  logic tick;
  logic advance;
  logic byteDone;
  logic mapped;
  logic apbAcc;
  logic apbDone;
  logic [31:0] readData;

  twm_sync #(.WIDTH(2)) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(lineSync)
  );

  assign sclS = lineSync[1];
  assign sdaS = lineSync[0];

  ////////////////////////////////////////////////////////////////////////////
  // phase timing; a slave that stretches the clock stalls phase one
  assign tick = (st_q.qCnt == 8'h00);
  assign advance = tick && !((st_q.phase == `TWM_PHASE_SCL) && !sclS);
  assign byteDone = (st_q.state == twm_pkg::TWM_BYTE) && advance && st_q.ctl.en
    && (st_q.phase == `TWM_PHASE_LAST) && (st_q.bitIdx == `TWM_BIT_ACK);

  function automatic logic bitDrive(input logic rxData, input logic [3:0] idx,
    input logic msb, input logic ackb);
    if (idx == `TWM_BIT_ACK)
      bitDrive = rxData ? ackb : 1'b0;
    else
      bitDrive = rxData ? 1'b0 : !msb;
  endfunction

  function automatic logic ownsBit(input logic rxData, input logic [3:0] idx);
    ownsBit = (idx == `TWM_BIT_ACK) ? rxData : !rxData;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign apbAcc = apbReq.psel && apbReq.penable;
  assign apbDone = apbAcc && st_q.pready;
  assign mapped = (apbReq.paddr == `TWM_ADDR_CTL) || (apbReq.paddr == `TWM_ADDR_DATA)
    || (apbReq.paddr == `TWM_ADDR_STAT) || (apbReq.paddr == `TWM_ADDR_RATE);

  always_comb
  begin
    readData = 32'h0000_0000;
    case (apbReq.paddr)
      `TWM_ADDR_CTL: readData[7:0] = {st_q.ctl.flag, st_q.ctl.ackEn, st_q.ctl.staReq,
        st_q.ctl.stoReq, st_q.ctl.wcol, st_q.ctl.en, 1'b0, st_q.ctl.ie};
      `TWM_ADDR_DATA: readData[7:0] = st_q.dataReg;
      // code keeps its low bits zero so masking the prescaler leaves it
      `TWM_ADDR_STAT: readData[7:0] = {st_q.code[7:`TWM_STAT_CODE_LO], 1'b0, st_q.presc};
      `TWM_ADDR_RATE: readData[7:0] = st_q.qLimit;
      default: readData = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    // one wait state: pready rises in the second access cycle
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (apbAcc && !st_q.pready)
    begin
      st_d.pready = 1'b1;
      st_d.pslverr = !mapped;
      st_d.prdata = readData;
    end
    if (apbDone && apbReq.pwrite)
    begin
      case (apbReq.paddr)
        `TWM_ADDR_CTL:
        begin
          if (apbReq.pwdata[`TWM_CTL_FLAG])
            st_d.ctl.flag = 1'b0;
          st_d.ctl.ackEn = apbReq.pwdata[`TWM_CTL_ACKEN];
          st_d.ctl.staReq = apbReq.pwdata[`TWM_CTL_STA];
          st_d.ctl.stoReq = apbReq.pwdata[`TWM_CTL_STO];
          st_d.ctl.en = apbReq.pwdata[`TWM_CTL_EN];
          st_d.ctl.ie = apbReq.pwdata[`TWM_CTL_IE];
        end
        `TWM_ADDR_DATA:
        begin
          if (st_q.ctl.flag)
          begin
            st_d.dataReg = apbReq.pwdata[7:0];
            st_d.ctl.wcol = 1'b0;
          end
          else
            st_d.ctl.wcol = 1'b1;
        end
        `TWM_ADDR_STAT: st_d.presc = apbReq.pwdata[`TWM_STAT_PRESC_HI:0];
        `TWM_ADDR_RATE: st_d.qLimit = apbReq.pwdata[7:0];
        default: st_d.presc = st_q.presc;
      endcase
    end

    // bus busy tracking from start and stop seen on the pins
    st_d.sclPrev = sclS;
    st_d.sdaPrev = sdaS;
    if (sclS && st_q.sclPrev && st_q.sdaPrev && !sdaS)
      st_d.busy = 1'b1;
    else if (sclS && !st_q.sdaPrev && sdaS)
      st_d.busy = 1'b0;

    if (tick)
      st_d.qCnt = advance ? st_q.qLimit : 8'h00;
    else
      st_d.qCnt = st_q.qCnt - 8'h01;

    // engine writes come last, so a hardware set of the flag beats a clear
    if (!st_q.ctl.en)
    begin
      st_d.state = twm_pkg::TWM_IDLE;
      st_d.sclOe = 1'b0;
      st_d.sdaOe = 1'b0;
      st_d.owner = 1'b0;
    end
    else
    begin
      unique case (st_q.state)
        twm_pkg::TWM_IDLE:
        begin
          st_d.sclOe = 1'b0;
          st_d.sdaOe = 1'b0;
          if (st_q.ctl.staReq && !st_q.ctl.flag)
            st_d.state = twm_pkg::TWM_WAITFREE;
        end
        twm_pkg::TWM_WAITFREE:
        begin
          if (!st_q.busy)
          begin
            st_d.state = twm_pkg::TWM_START;
            st_d.phase = 2'h0;
            st_d.qCnt = st_q.qLimit;
          end
        end
        twm_pkg::TWM_START:
        begin
          if (advance)
          begin
            st_d.phase = st_q.phase + 2'h1;
            unique case (st_q.phase)
              2'h0: st_d.sclOe = 1'b0;
              2'h1: st_d.sdaOe = 1'b1;
              2'h2: st_d.sclOe = 1'b1;
              2'h3:
              begin
                st_d.code = st_q.owner ? `TWM_ST_RESTART : `TWM_ST_START;
                st_d.owner = 1'b1;
                st_d.addrPhase = 1'b1;
                st_d.ctl.flag = 1'b1;
                st_d.state = twm_pkg::TWM_HOLD;
              end
            endcase
          end
        end
        twm_pkg::TWM_BYTE:
        begin
          if (advance)
          begin
            st_d.phase = st_q.phase + 2'h1;
            unique case (st_q.phase)
              2'h0: st_d.sclOe = 1'b0;
              2'h1:
              begin
                if (ownsBit(st_q.rxMode && !st_q.addrPhase, st_q.bitIdx)
                  && !st_q.sdaOe && !sdaS)
                begin
                  // another master pulled data low: give up the bus
                  st_d.state = twm_pkg::TWM_HOLD;
                  st_d.sclOe = 1'b0;
                  st_d.sdaOe = 1'b0;
                  st_d.owner = 1'b0;
                  st_d.code = `TWM_ST_ARB;
                  st_d.ctl.flag = 1'b1;
                end
                else if (st_q.bitIdx == `TWM_BIT_ACK)
                  st_d.ackSeen = !sdaS;
                else
                  st_d.shift = {st_q.shift[6:0], sdaS}; // tx shifts out, rx in
              end
              2'h2: st_d.sclOe = 1'b1;
              2'h3:
              begin
                if (st_q.bitIdx == `TWM_BIT_ACK)
                begin
                  st_d.ctl.flag = 1'b1;
                  st_d.state = twm_pkg::TWM_HOLD;
                  st_d.sdaOe = 1'b0;
                  if (st_q.addrPhase)
                  begin
                    st_d.addrPhase = 1'b0;
                    if (st_q.rxMode)
                      st_d.code = st_q.ackSeen ? `TWM_ST_AR_ACK : `TWM_ST_AR_NACK;
                    else
                      st_d.code = st_q.ackSeen ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
                  end
                  else if (st_q.rxMode)
                  begin
                    st_d.dataReg = st_q.shift;
                    st_d.code = st_q.ackBit ? `TWM_ST_RX_ACK : `TWM_ST_RX_NACK;
                  end
                  else
                    st_d.code = st_q.ackSeen ? `TWM_ST_TX_ACK : `TWM_ST_TX_NACK;
                end
                else
                begin
                  st_d.bitIdx = st_q.bitIdx + 4'h1;
                  st_d.sdaOe = bitDrive(st_q.rxMode && !st_q.addrPhase,
                    st_q.bitIdx + 4'h1, st_q.shift[7], st_q.ackBit);
                end
              end
            endcase
          end
        end
        twm_pkg::TWM_STOP:
        begin
          if (advance)
          begin
            st_d.phase = st_q.phase + 2'h1;
            unique case (st_q.phase)
              2'h0: st_d.sclOe = 1'b0;
              2'h1: st_d.sdaOe = 1'b0;
              2'h2: st_d.sdaOe = 1'b0;
              2'h3:
              begin
                st_d.ctl.stoReq = 1'b0;
                st_d.owner = 1'b0;
                st_d.code = `TWM_ST_IDLE;
                st_d.state = st_q.ctl.staReq ? twm_pkg::TWM_WAITFREE : twm_pkg::TWM_IDLE;
              end
            endcase
          end
        end
        twm_pkg::TWM_HOLD:
        begin
          st_d.sclOe = st_q.owner;
          if (!st_q.ctl.flag)
          begin
            st_d.phase = 2'h0;
            st_d.qCnt = st_q.qLimit;
            if (st_q.owner && st_q.ctl.stoReq)
            begin
              st_d.state = twm_pkg::TWM_STOP;
              st_d.sdaOe = 1'b1;
            end
            else if (st_q.ctl.staReq)
            begin
              // repeated start keeps the bus; after a loss wait for it
              st_d.state = st_q.owner ? twm_pkg::TWM_START : twm_pkg::TWM_WAITFREE;
              st_d.sdaOe = 1'b0;
            end
            else if (st_q.owner)
            begin
              st_d.state = twm_pkg::TWM_BYTE;
              st_d.bitIdx = 4'h0;
              st_d.shift = st_q.dataReg;
              st_d.ackBit = st_q.ctl.ackEn;
              if (st_q.addrPhase)
                st_d.rxMode = st_q.dataReg[0];
              st_d.sdaOe = bitDrive(st_q.rxMode && !st_q.addrPhase, 4'h0,
                st_q.dataReg[7], st_q.ctl.ackEn);
            end
            else
            begin
              st_d.state = twm_pkg::TWM_IDLE;
              st_d.sclOe = 1'b0;
              st_d.sdaOe = 1'b0;
            end
          end
        end
        default: st_d.state = twm_pkg::TWM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.state <= twm_pkg::TWM_IDLE;
      st_q.qLimit <= `TWM_RATE_RESET;
      st_q.qCnt <= `TWM_RATE_RESET;
      st_q.code <= `TWM_ST_IDLE;
      st_q.sclPrev <= 1'b1;
      st_q.sdaPrev <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign sclOe = st_q.sclOe;
  assign sdaOe = st_q.sdaOe;
  // open drain: the driven level is always low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_holdStep;
    st_q.state == twm_pkg::TWM_HOLD && !st_q.ctl.flag && st_q.ctl.en;
  endsequence

  sequence s_ownedStep;
    s_holdStep ##0 st_q.owner;
  endsequence

  a_restart_go: assert property (s_ownedStep ##0 (st_q.ctl.staReq && !st_q.ctl.stoReq)
    |=> st_q.state == twm_pkg::TWM_START)
    else $error("repeated start not taken");
  a_stop_go: assert property (s_ownedStep ##0 st_q.ctl.stoReq
    |=> st_q.state == twm_pkg::TWM_STOP && sdaOe)
    else $error("stop not taken");
  a_stop_clears: assert property (st_q.state == twm_pkg::TWM_STOP
    ##1 (st_q.state != twm_pkg::TWM_STOP && st_q.ctl.en) |-> !st_q.ctl.stoReq)
    else $error("stop request not cleared");
  a_start_code: assert property (st_q.state == twm_pkg::TWM_START && advance
    && st_q.ctl.en && st_q.phase == `TWM_PHASE_LAST
    |=> st_q.ctl.flag && (st_q.code == `TWM_ST_START || st_q.code == `TWM_ST_RESTART))
    else $error("start status wrong");
  a_wait_busy: assert property (st_q.state == twm_pkg::TWM_WAITFREE && st_q.busy
    |=> st_q.state != twm_pkg::TWM_START)
    else $error("start on busy bus");
  a_hold_stretch: assert property (st_q.state == twm_pkg::TWM_HOLD && st_q.owner
    && st_q.ctl.flag |-> sclOe)
    else $error("clock not held low");
  a_wcol_set: assert property (apbDone && apbReq.pwrite && apbReq.paddr == `TWM_ADDR_DATA
    && !st_q.ctl.flag |=> st_q.ctl.wcol && st_q.dataReg == $past(st_q.dataReg))
    else $error("collision not flagged");
  a_addr_code: assert property (byteDone && st_q.addrPhase && st_q.rxMode
    |=> st_q.ctl.flag && (st_q.code == `TWM_ST_AR_ACK || st_q.code == `TWM_ST_AR_NACK))
    else $error("read address status wrong");
  a_tx_code: assert property (byteDone && !st_q.addrPhase && !st_q.rxMode
    |=> st_q.code == ($past(st_q.ackSeen) ? `TWM_ST_TX_ACK : `TWM_ST_TX_NACK))
    else $error("data sent status wrong");
  a_arb_free: assert property (s_holdStep ##0 (!st_q.owner && !st_q.ctl.staReq)
    |=> st_q.state == twm_pkg::TWM_IDLE && !sclOe && !sdaOe)
    else $error("bus not released");
  a_flag_wait: assert property (st_q.state == twm_pkg::TWM_HOLD && st_q.ctl.flag
    && st_q.ctl.en |=> st_q.state == twm_pkg::TWM_HOLD)
    else $error("step without flag clear");

endmodule

//--- verif/twm_slave_model.sv
module twm_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h2A, // address this model answers
  parameter logic [7:0] NACK_BYTE = 8'hFF // written byte refused with nack
) (
  input wire logic scl, // clock line level
  input wire logic sda, // data line level
  input wire logic [7:0] txByte, // byte returned on reads
  output logic sdaPull // pulls data line low when high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic restart;
  task automatic getByte(output logic [7:0] b);
    for (int k = 7; k >= 0; k--)
    begin
      @(posedge scl);
      b[k] = sda;
    end
  endtask
  task automatic ackBit(input logic a);
    @(negedge scl);
    sdaPull = a;
    @(negedge scl);
    sdaPull = 1'b0;
  endtask
  task automatic frame();
    logic [7:0] b;
    logic m;
    getByte(b);
    if (b[7:1] != SLV_ADDR)
    begin
      wait (1'b0);
    end
    ackBit(1'b1);
    if (b[0])
    begin
      forever
      begin
        for (int k = 7; k >= 0; k--)
        begin
          sdaPull = !txByte[k];
          @(negedge scl);
        end
        sdaPull = 1'b0;
        @(posedge scl);
        m = sda;
        @(negedge scl);
        // a nack from the master ends our driving until the next frame
        if (m)
        begin
          wait (1'b0);
        end
      end
    end
    forever
    begin
      getByte(b);
      ackBit(b != NACK_BYTE);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sdaPull = 1'b0;
    restart = 1'b0;
    forever
    begin
      if (!restart)
        @(negedge sda iff scl === 1'b1);
      restart = 1'b0;
      // any data edge with the clock high is a start or stop: abandon the frame
      fork
        frame();
        begin
          @(sda iff scl === 1'b1);
          restart = !sda;
        end
      join_any
      disable fork;
      sdaPull = 1'b0;
    end
  end
endmodule

//--- verif/test_two_wire_master_txrx_control.sv
`include "twm_params.svh"
module test_two_wire_master_txrx_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wrData;
    logic [7:0] dat;
    logic [7:0] ctl;
    logic [7:0] st;
    logic chkRx;
  } twm_row_t;
  logic clk_sys, rst, sclOut, sclOe, sdaOut, sdaOe, pready, pslverr, slvPull, arbPull;
  logic scl, sda, perr;
  logic [31:0] prdata, rd;
  twm_pkg::twm_apb_req_t apbReq;
  int errTotal, compares;
  twm_row_t rows [11] = '{
    '{1'b0, 8'h00, 8'hA4, 8'h08, 1'b0},
    '{1'b1, 8'h54, 8'h84, 8'h18, 1'b0},
    '{1'b1, 8'h3C, 8'h84, 8'h28, 1'b0},
    '{1'b1, 8'hFF, 8'h84, 8'h30, 1'b0},
    '{1'b0, 8'h00, 8'hA4, 8'h10, 1'b0},
    '{1'b1, 8'h55, 8'h84, 8'h40, 1'b0},
    '{1'b0, 8'h00, 8'hC4, 8'h50, 1'b1},
    '{1'b0, 8'h00, 8'h84, 8'h58, 1'b1},
    '{1'b0, 8'h00, 8'hA4, 8'h10, 1'b0},
    '{1'b1, 8'h20, 8'h84, 8'h20, 1'b0},
    '{1'b0, 8'h00, 8'hB4, 8'h08, 1'b0}
  };
  // open-drain lines with pull-up: low while any party pulls
  assign scl = !sclOe;
  assign sda = !(sdaOe | slvPull | arbPull);
  twm_master twm_master_inst (
    .clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe)
  );
  twm_slave_model twm_slave_model_inst (
    .scl(scl), .sda(sda), .txByte(8'hC5), .sdaPull(slvPull)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic completeRun();
    $display("checks %0d errors %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      errTotal++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, a, {24'h000000, d}};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    perr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n == 50)
    begin
      chk(32'h0, 32'h1, "apb timeout");
      completeRun();
    end
  endtask
  // polls the control register until one bit reaches a level
  task automatic waitCtl(input int pos, input logic val);
    int n;
    for (n = 0; n < 400; n++)
    begin
      apb(1'b0, `TWM_ADDR_CTL, 8'h00);
      if (rd[pos] === val)
        break;
    end
    if (n == 400)
    begin
      chk(32'h0, 32'h1, "control wait timeout");
      completeRun();
    end
  endtask
  task automatic stat(input logic [7:0] exp);
    apb(1'b0, `TWM_ADDR_STAT, 8'h00);
    chk(rd & 32'hF8, {24'h000000, exp}, "status code");
    chk({30'h0, rd[1:0]}, 32'h3, "prescaler bits");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst = 1'b1;
    apbReq = '0;
    arbPull = 1'b0;
    errTotal = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `TWM_ADDR_CTL, 8'h00);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, `TWM_ADDR_DATA, 8'h00);
    chk(rd, 32'h0, "data reset");
    apb(1'b0, `TWM_ADDR_STAT, 8'h00);
    chk(rd, 32'hF8, "status reset");
    apb(1'b0, `TWM_ADDR_RATE, 8'h00);
    chk(rd, 32'h7C, "rate reset");
    apb(1'b0, 12'h010, 8'h00);
    chk({rd[30:0], perr}, 32'h1, "unmapped read");
    // short bit time keeps the run brief; nonzero prescaler must not disturb codes
    apb(1'b1, `TWM_ADDR_RATE, 8'h05);
    apb(1'b1, `TWM_ADDR_STAT, 8'h03);
    foreach (rows[i])
    begin
      if (rows[i].wrData)
        apb(1'b1, `TWM_ADDR_DATA, rows[i].dat);
      apb(1'b1, `TWM_ADDR_CTL, rows[i].ctl);
      waitCtl(7, 1'b1);
      stat(rows[i].st);
      chk({31'h0, scl}, 32'h0, "clock line held");
      apb(1'b0, `TWM_ADDR_CTL, 8'h00);
      chk({30'h0, rd[7], rd[4]}, 32'h2, "flag kept, stop clear");
      if (rows[i].chkRx)
      begin
        apb(1'b0, `TWM_ADDR_DATA, 8'h00);
        chk(rd, 32'hC5, "received byte");
      end
    end
    apb(1'b1, `TWM_ADDR_CTL, 8'h94);
    waitCtl(4, 1'b0);
    stat(8'hF8);
    chk({30'h0, sclOe, sdaOe}, 32'h0, "lines free after stop");
    chk({30'h0, sclOut, sdaOut}, 32'h0, "open drain level low");
    apb(1'b1, `TWM_ADDR_DATA, 8'h77);
    apb(1'b0, `TWM_ADDR_CTL, 8'h00);
    chk({30'h0, rd[7], rd[3]}, 32'h1, "write collision");
    apb(1'b1, `TWM_ADDR_CTL, 8'hA4);
    waitCtl(7, 1'b1);
    stat(8'h08);
    // a competing master holds the data line low through our address bits
    apb(1'b1, `TWM_ADDR_DATA, 8'hAA);
    arbPull <= 1'b1;
    apb(1'b1, `TWM_ADDR_CTL, 8'h84);
    waitCtl(7, 1'b1);
    stat(8'h38);
    apb(1'b1, `TWM_ADDR_CTL, 8'hA4);
    repeat (200) @(posedge clk_sys);
    apb(1'b0, `TWM_ADDR_CTL, 8'h00);
    chk({31'h0, rd[7]}, 32'h0, "no start on busy bus");
    chk({30'h0, sclOe, sdaOe}, 32'h0, "bus released");
    arbPull <= 1'b0;
    waitCtl(7, 1'b1);
    stat(8'h08);
    apb(1'b1, `TWM_ADDR_CTL, 8'h94);
    waitCtl(4, 1'b0);
    // second loss: a clear without start must just let the bus go
    apb(1'b1, `TWM_ADDR_CTL, 8'hA4);
    waitCtl(7, 1'b1);
    apb(1'b1, `TWM_ADDR_DATA, 8'hAA);
    arbPull <= 1'b1;
    apb(1'b1, `TWM_ADDR_CTL, 8'h84);
    waitCtl(7, 1'b1);
    stat(8'h38);
    apb(1'b1, `TWM_ADDR_CTL, 8'h84);
    repeat (20) @(posedge clk_sys);
    chk({30'h0, sclOe, sdaOe}, 32'h0, "lines free after loss");
    apb(1'b0, `TWM_ADDR_CTL, 8'h00);
    chk({31'h0, rd[7]}, 32'h0, "no step after release");
    arbPull <= 1'b0;
    completeRun();
  end
endmodule
